// ---- rtl/tsg_top.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "tsg_regs.svh"

// Overview of operation
// RQ1: Mode field 00 sine, 01 dc level, 10 external bitstream, 11 pulse.
// RQ2: Sine frequency is 250 Hz over 2^octave times (num+1)/(den+1).
// RQ3: Sine frequency is set for 4.096 MHz and scales with the clock.
// RQ4: Writing numerator or denominator restarts the sine at zero crossing.
// RQ5: Sync high in sine mode forces the phase back to zero crossing.
// RQ6: Range code steps 6 dB from 000 at 0 dB to 110 at -36 dB.
// RQ7: Sine attenuation is 0.5 dB per count, 0 to -119.5 dB.
// RQ8: Attenuation codes with upper nibble all ones mute the sine.
// RQ9: Sine level in dB is range attenuation plus digital attenuation.
// RQ10: Host should prefer low range and small digital attenuation.
// RQ11: Dc level is a signed 24-bit word passed to the modulator.
// RQ12: Dc output is scaled by the selected analog range.
// RQ13: Pulse mode uses low level while sync is low, high level otherwise.
// RQ14: Pulse codes are 5-bit sign-magnitude style, passed as given.
// RQ15: Pulse output ignores the analog range field.
// RQ16: External mode feeds the outside bitstream straight to the converter.
// RQ17: Modulator turns sine or dc sample into a ones-density bitstream.
// RQ18: Undefined range code 111 acts as the lowest range 110.
// RQ19: New mode, range and level fields take effect at the next bit tick.
module tsg_top (
	input wire logic clk_sys, // System clock
	input wire logic reset, // Asynchronous reset
	input wire logic [7:0] reg_addr, // Register byte address
	input wire logic [31:0] reg_wdata, // Register write data
	input wire logic reg_wr, // Write strobe
	input wire logic reg_rd, // Read strobe
	input wire logic sync_in, // Sync pin
	input wire logic switch_or_bitstream_in, // Switch or bitstream pin
	output var logic [31:0] reg_rdata_q, // Read data
	output var logic dac_bit_q, // Ones-density stream to main converter
	output var logic [2:0] dac_range_q, // Range to current generator
	output var logic [23:0] mod_sample_q, // Modulator input sample
	output var logic [4:0] pulse_code_q, // Pulse converter code
	output var logic pulse_en_q // Pulse converter selected
);

	// ==========================================
	// Helper functions

	// Address match for one register
	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		return a == o;
	endfunction

	// Quarter-wave sine table, 16 segments, 23-bit magnitude
	function automatic logic [22:0] qtab(input logic [4:0] i);
		logic [22:0] v;
		v = 23'h000000;
		case (i)
			5'h00: v = 23'h000000;
			5'h01: v = 23'h0C8BD3;
			5'h02: v = 23'h18F8B8;
			5'h03: v = 23'h25280C;
			5'h04: v = 23'h30FBC5;
			5'h05: v = 23'h3C56BA;
			5'h06: v = 23'h471CEC;
			5'h07: v = 23'h5133CB;
			5'h08: v = 23'h5A827A;
			5'h09: v = 23'h62F1FE;
			5'h0A: v = 23'h6A6D99;
			5'h0B: v = 23'h70E2CC;
			5'h0C: v = 23'h7641AF;
			5'h0D: v = 23'h7A7D05;
			5'h0E: v = 23'h7D8A5B;
			5'h0F: v = 23'h7F6237;
			5'h10: v = 23'h7FFFFF;
			default: v = 23'h7FFFFF;
		endcase
		return v;
	endfunction

	// Gain for 0 to 5.5 dB in half-dB steps, 0x8000 is unity
	function automatic logic [15:0] att_mant(input logic [7:0] r);
		logic [15:0] m;
		m = 16'h8000;
		case (r)
			8'h00: m = 16'h8000;
			8'h01: m = 16'h78D7;
			8'h02: m = 16'h7215;
			8'h03: m = 16'h6BB3;
			8'h04: m = 16'h65AD;
			8'h05: m = 16'h5FFD;
			8'h06: m = 16'h5A9E;
			8'h07: m = 16'h558C;
			8'h08: m = 16'h50C3;
			8'h09: m = 16'h4C3F;
			8'h0A: m = 16'h47FB;
			8'h0B: m = 16'h43F4;
			default: m = 16'h43F4;
		endcase
		return m;
	endfunction

	// ==========================================
	// Register state
	tsg_pkg::tsg_cfg_t cfg_q, cfg_act_q;
	tsg_pkg::tsg_pulse_t pulse_q, pulse_act_q;
	logic [3:0] num_q;
	logic [7:0] den_q, att_q, att_act_q;
	logic [23:0] dc_q, dc_act_q;
	logic sync_m_q, sync_s_q, sw_m_q, sw_s_q;
	logic [3:0] div_q;
	logic [7:0] acc_q;
	logic [14:0] phase_q;
	logic [23:0] mod_acc_q;

	// ==========================================
	// Bus decode
	wire logic wr_cfg = reg_wr && hit(reg_addr, `TSG_OFF_CFG);
	wire logic wr_num = reg_wr && hit(reg_addr, `TSG_OFF_NUM);
	wire logic wr_den = reg_wr && hit(reg_addr, `TSG_OFF_DEN);
	wire logic wr_att = reg_wr && hit(reg_addr, `TSG_OFF_ATT);
	wire logic wr_dc = reg_wr && hit(reg_addr, `TSG_OFF_DC);
	wire logic wr_pulse = reg_wr && hit(reg_addr, `TSG_OFF_PULSE);

	// Host register writes
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			cfg_q <= `TSG_RST_CFG;
			num_q <= `TSG_RST_NUM;
			den_q <= `TSG_RST_DEN;
			att_q <= `TSG_RST_ATT;
			dc_q <= `TSG_RST_DC;
			pulse_q <= `TSG_RST_PULSE;
		end else begin
			if (wr_cfg) cfg_q <= reg_wdata[`TSG_CFG_HI:0];
			if (wr_num) num_q <= reg_wdata[`TSG_NUM_HI:0];
			if (wr_den) den_q <= reg_wdata[`TSG_DEN_HI:0];
			if (wr_att) att_q <= reg_wdata[`TSG_ATT_HI:0];
			if (wr_dc) dc_q <= reg_wdata[`TSG_DC_HI:0];
			if (wr_pulse) pulse_q <= {reg_wdata[`TSG_PHI_HI:`TSG_PHI_LO], reg_wdata[`TSG_PLO_HI:0]};
		end
	end

	// ==========================================
	// Pin synchronisers and bit tick

	// Two flops per pin, only the second is used
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			sync_m_q <= 1'b0;
			sync_s_q <= 1'b0;
			sw_m_q <= 1'b0;
			sw_s_q <= 1'b0;
		end else begin
			sync_m_q <= sync_in;
			sync_s_q <= sync_m_q;
			sw_m_q <= switch_or_bitstream_in;
			sw_s_q <= sw_m_q;
		end
	end

	// Bit tick every 16 clocks, the ones-density rate
	wire logic tick = (div_q == `TSG_BIT_DIV_LAST);

	// Active copies switch only on a tick so each source changes cleanly
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			div_q <= 4'h0;
			cfg_act_q <= `TSG_RST_CFG;
			att_act_q <= `TSG_RST_ATT;
			dc_act_q <= `TSG_RST_DC;
			pulse_act_q <= `TSG_RST_PULSE;
		end else begin
			div_q <= div_q + 4'h1;
			if (tick) begin // RQ19
				cfg_act_q <= cfg_q;
				att_act_q <= att_q;
				dc_act_q <= dc_q;
				pulse_act_q <= pulse_q;
			end
		end
	end

	// ==========================================
	// Mode decode
	wire logic m_sine = (cfg_act_q.mode == tsg_pkg::TSG_MODE_SINE); // RQ1
	wire logic m_dc = (cfg_act_q.mode == tsg_pkg::TSG_MODE_DC); // RQ1
	wire logic m_bits = (cfg_act_q.mode == tsg_pkg::TSG_MODE_BITS); // RQ1
	wire logic m_pulse = (cfg_act_q.mode == tsg_pkg::TSG_MODE_PULSE); // RQ1

	// ==========================================
	// Sine phase generator
	// A full cycle is 32768 phase units; at full rate two units per clock
	// give 16384 clocks, which is 250 Hz at 4.096 MHz and tracks the clock
	// Sync is level sensitive: in sine mode the phase stays at zero while it is high
	wire logic restart = wr_num || wr_den || (m_sine && sync_s_q); // RQ4 RQ5
	wire logic [8:0] frac_sum = {1'b0, acc_q} + {5'h00, num_q} + 9'h001; // RQ2
	wire logic [8:0] den_one = {1'b0, den_q} + 9'h001;
	wire logic step = (frac_sum >= den_one);
	wire logic [8:0] frac_left = frac_sum - den_one;
	wire logic [7:0] acc_d = step ? frac_left[7:0] : frac_sum[7:0];
	wire logic [14:0] phase_inc = cfg_act_q.octave ? 15'h0001 : 15'h0002; // RQ2 RQ3

	// Phase accumulator, restarts at the zero crossing
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			acc_q <= 8'h00;
			phase_q <= 15'h0000;
		end else if (restart) begin
			acc_q <= 8'h00;
			phase_q <= 15'h0000;
		end else begin
			acc_q <= acc_d;
			if (step) phase_q <= phase_q + phase_inc;
		end
	end

	// ==========================================
	// Sine value and digital attenuation
	wire logic [12:0] qpos = phase_q[13] ? ~phase_q[12:0] : phase_q[12:0];
	wire logic [4:0] qidx = {1'b0, qpos[12:9]};
	wire logic [22:0] tab_lo = qtab(qidx);
	wire logic [22:0] tab_hi = qtab(qidx + 5'h01);
	wire logic [22:0] tab_diff = tab_hi - tab_lo;
	wire logic [31:0] interp_p = {9'h000, tab_diff} * {23'h000000, qpos[8:0]};
	wire logic [22:0] sine_mag = tab_lo + interp_p[31:9];
	wire logic sine_neg = phase_q[14];
	wire logic [23:0] sine_raw = sine_neg ? -{1'b0, sine_mag} : {1'b0, sine_mag};

	// Half-dB steps: whole 6 dB steps by shift, remainder by multiply
	wire logic [7:0] att_six = att_act_q / `TSG_ATT_PER_6DB; // RQ7
	wire logic [7:0] att_six_x = att_six * `TSG_ATT_PER_6DB;
	wire logic [7:0] att_rem = att_act_q - att_six_x;
	wire logic [15:0] att_m = att_mant(att_rem);
	wire logic [38:0] att_p = {16'h0000, sine_mag} * {23'h000000, att_m};
	wire logic [22:0] att_mag = att_p[37:15] >> att_six; // RQ7 RQ9
	wire logic mute = (att_act_q[7:4] == `TSG_MUTE_NIB); // RQ8
	wire logic [23:0] att_signed = sine_neg ? -{1'b0, att_mag} : {1'b0, att_mag};
	wire logic [23:0] sine_val = mute ? 24'h000000 : att_signed; // RQ8

	// ==========================================
	// Source selection
	// Dc word is signed and passes unchanged; range scales it downstream
	wire logic [23:0] sample_d = m_dc ? dc_act_q : // RQ11 RQ12
		(m_sine ? sine_val : 24'h000000);
	// Host keeps attenuation small and lowers range for best noise
	wire logic [2:0] range_d = (cfg_act_q.range == `TSG_RANGE_BAD) ? // RQ6 RQ10 RQ18
		`TSG_RANGE_LOW : cfg_act_q.range;
	// Pulse code bypasses the range path entirely
	wire logic [4:0] pcode_d = !m_pulse ? 5'h00 : // RQ13 RQ14 RQ15
		(sync_s_q ? pulse_act_q.high : pulse_act_q.low);

	// ==========================================
	// First-order ones-density modulator
	// Full scale maps to 25 to 75 percent ones, matching the external stream
	wire logic [23:0] mod_half = {mod_sample_q[23], mod_sample_q[23:1]};
	wire logic [23:0] mod_term = 24'h800000 + mod_half;
	wire logic [24:0] mod_sum = {1'b0, mod_acc_q} + {1'b0, mod_term}; // RQ17
	wire logic bit_d = m_bits ? sw_s_q : // RQ16
		(tick ? mod_sum[24] : dac_bit_q);

	// Output stage
	// Bit only moves on a tick outside bitstream mode, so it lasts 16 clocks
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			mod_acc_q <= 24'h000000;
			mod_sample_q <= 24'h000000;
			dac_bit_q <= 1'b0;
			dac_range_q <= 3'h0;
			pulse_code_q <= 5'h00;
			pulse_en_q <= 1'b0;
		end else begin
			if (tick) mod_acc_q <= mod_sum[23:0]; // RQ17
			mod_sample_q <= sample_d;
			dac_bit_q <= bit_d;
			dac_range_q <= range_d;
			pulse_code_q <= pcode_d;
			pulse_en_q <= m_pulse;
		end
	end

	// ==========================================
	// Read-back
	// Status word: phase, active mode and the synced pins
	wire logic [31:0] stat_w = {10'h000, sw_s_q, sync_s_q, 2'b00,
		cfg_act_q.mode, 1'b0, phase_q};
	wire logic [31:0] rd_val =
		hit(reg_addr, `TSG_OFF_CFG) ? {26'h0000000, cfg_q} :
		hit(reg_addr, `TSG_OFF_NUM) ? {28'h0000000, num_q} :
		hit(reg_addr, `TSG_OFF_DEN) ? {24'h000000, den_q} :
		hit(reg_addr, `TSG_OFF_ATT) ? {24'h000000, att_q} :
		hit(reg_addr, `TSG_OFF_DC) ? {8'h00, dc_q} :
		hit(reg_addr, `TSG_OFF_PULSE) ? {19'h00000, pulse_q.high, 3'h0, pulse_q.low} :
		hit(reg_addr, `TSG_OFF_STAT) ? stat_w : 32'h00000000;

	// Read data stand for the one cycle after the strobe
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) reg_rdata_q <= 32'h00000000;
		else reg_rdata_q <= reg_rd ? rd_val : 32'h00000000;
	end

	// ==========================================
	// Assertions
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	// Host write of either ratio field
	sequence s_ratio_write;
		wr_num || wr_den;
	endsequence

	sequence s_full_rate;
		(num_q == 4'h0 && den_q == 8'h00 && !cfg_act_q.octave && !restart);
	endsequence

	a_pulse_mode_flag: assert property (m_pulse |=> pulse_en_q) // RQ1
		else $error("pulse mode did not select pulse converter");
	a_ratio_restart: assert property (s_ratio_write |=> phase_q == 15'h0000) // RQ4
		else $error("frequency write did not restart phase");
	a_sync_zero: assert property ((m_sine && sync_s_q) |=> phase_q == 15'h0000) // RQ5
		else $error("sync did not zero sine phase");
	a_full_rate_step: assert property (s_full_rate [*3] |=> // RQ2
		phase_q == $past(phase_q, 3) + 15'h0006)
		else $error("sine phase rate wrong at full frequency");
	a_att_mute: assert property ((m_sine && mute) |=> mod_sample_q == 24'h000000) // RQ8
		else $error("muted sine produced a sample");
	a_att_unity: assert property ((m_sine && att_act_q == 8'h00) |=> // RQ7
		mod_sample_q == $past(sine_raw))
		else $error("zero attenuation changed the sine");
	a_dc_pass: assert property (m_dc |=> mod_sample_q == $past(dc_act_q)) // RQ11
		else $error("dc level not passed to modulator");
	a_pulse_select: assert property (m_pulse |=> // RQ13
		pulse_code_q == ($past(sync_s_q) ? $past(pulse_act_q.high) : $past(pulse_act_q.low)))
		else $error("pulse level not chosen by sync");
	a_range_clamp: assert property (dac_range_q != `TSG_RANGE_BAD) // RQ18
		else $error("undefined range code reached output");
	a_bits_direct: assert property (m_bits |=> dac_bit_q == $past(sw_s_q)) // RQ16
		else $error("external bitstream not passed through");
	a_cfg_hold: assert property (!tick |=> $stable(cfg_act_q) && $stable(dc_act_q)) // RQ19
		else $error("active fields changed off the tick");
	a_cfg_apply: assert property (tick |=> cfg_act_q == $past(cfg_q)) // RQ19
		else $error("active fields not taken at the tick");
	// Modulator bit holds between ticks
	a_bit_hold: assert property ((!m_bits && !tick) |=> $stable(dac_bit_q)) // RQ17
		else $error("modulator bit changed off the tick");

endmodule // tsg_top

`default_nettype wire

// ---- rtl/tsg_regs.svh ----
`ifndef TSG_REGS_SVH
`define TSG_REGS_SVH
// ==========================================
// Register offsets
`define TSG_OFF_CFG 8'h00
`define TSG_OFF_NUM 8'h04
`define TSG_OFF_DEN 8'h08
`define TSG_OFF_ATT 8'h0C
`define TSG_OFF_DC 8'h10
`define TSG_OFF_PULSE 8'h14
`define TSG_OFF_STAT 8'h18
// ==========================================
// Field positions
`define TSG_CFG_HI 5
`define TSG_NUM_HI 3
`define TSG_DEN_HI 7
`define TSG_ATT_HI 7
`define TSG_DC_HI 23
`define TSG_PLO_HI 4
`define TSG_PHI_LO 8
`define TSG_PHI_HI 12
// ==========================================
// Reset values
`define TSG_RST_CFG 6'h00
`define TSG_RST_NUM 4'h0
`define TSG_RST_DEN 8'h00
`define TSG_RST_ATT 8'h00
`define TSG_RST_DC 24'h000000
`define TSG_RST_PULSE 10'h000
// ==========================================
// Timing and coding constants
`define TSG_BIT_DIV_LAST 4'hF
`define TSG_MUTE_NIB 4'hF
`define TSG_RANGE_BAD 3'h7
`define TSG_RANGE_LOW 3'h6
`define TSG_ATT_PER_6DB 8'h0C
`endif

// ---- rtl/tsg_pkg.sv ----
// ==========================================
// Shared types
package tsg_pkg;
	typedef enum logic [1:0] {
		TSG_MODE_SINE,
		TSG_MODE_DC,
		TSG_MODE_BITS,
		TSG_MODE_PULSE
	} tsg_mode_t;

	typedef struct packed {
		logic octave;
		logic [2:0] range;
		tsg_mode_t mode;
	} tsg_cfg_t;

	typedef struct packed {
		logic [4:0] high;
		logic [4:0] low;
	} tsg_pulse_t;
endpackage

// ---- tb/tsg_host_pins.sv ----
`timescale 1ns/100ps
`default_nettype none

// ==========================================
// Controller side pins: sync level and a 75% ones stream
module tsg_host_pins (
	input wire logic clk_sys, // System clock
	input wire logic reset, // Asynchronous reset
	input wire logic sync_req, // Bench asks for sync high
	output var logic sync_q, // Sync pin
	output var logic bit_q // Switch or bitstream pin
);
	logic [3:0] slot_q;
	logic [1:0] idx_q;

	// Pins change right after the edge; one stream bit lasts 16 clocks
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			slot_q <= 4'h0;
			idx_q <= 2'h0;
			sync_q <= 1'b0;
			bit_q <= 1'b0;
		end else begin
			sync_q <= sync_req;
			slot_q <= slot_q + 4'h1;
			if (slot_q == 4'hF) begin
				idx_q <= idx_q + 2'h1;
				bit_q <= (idx_q != 2'h3);
			end
		end
	end
endmodule // tsg_host_pins

`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "tsg_regs.svh"

// ==========================================
// Bench top
module tb;
	logic clk_sys, reset, reg_wr, reg_rd, sync_req, sync_in, bit_pin;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata_q, v;
	logic dac_bit_q, pulse_en_q;
	logic [2:0] dac_range_q;
	logic [23:0] mod_sample_q;
	logic [4:0] pulse_code_q;
	logic [14:0] ph;
	logic [3:0] h;
	int fails, checks, cnt;
	logic [23:0] dcv[4] = '{24'h000000, 24'h3FFFFF, 24'hC00000, 24'h800001};
	int dce[4] = '{512, 640, 384, 256};
	logic [3:0] fm[5] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'hA};
	logic [7:0] fn[5] = '{8'h00, 8'h00, 8'h01, 8'h03, 8'h31};
	logic fo[5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
	int fk[5] = '{16, 16, 16, 16, 50};
	logic [14:0] fe[5] = '{15'h20, 15'h10, 15'h10, 15'h08, 15'h16};

	tsg_top dut_u (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .sync_in(sync_in), .switch_or_bitstream_in(bit_pin),
		.reg_rdata_q(reg_rdata_q), .dac_bit_q(dac_bit_q), .dac_range_q(dac_range_q),
		.mod_sample_q(mod_sample_q), .pulse_code_q(pulse_code_q), .pulse_en_q(pulse_en_q));
	tsg_host_pins host_u (.clk_sys(clk_sys), .reset(reset), .sync_req(sync_req),
		.sync_q(sync_in), .bit_q(bit_pin));

	// ==========================================
	// Clock, bus tasks and comparison
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	task automatic idle(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata_q;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Configure, let the next bit tick apply it, confirm the active mode
	task automatic cfg(input logic [5:0] c);
		wr(`TSG_OFF_CFG, {26'h0, c});
		idle(40);
		rd(`TSG_OFF_STAT, v);
		chk({30'h0, v[17:16]}, {30'h0, c[1:0]});
	endtask
	task automatic summarize();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Watchdog well beyond the expected run
	initial begin
		#3000000;
		fails++;
		summarize();
	end

	// ==========================================
	// Test sequence
	initial begin
		reset = 1'b1;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		sync_req = 1'b0;
		repeat (6) @(posedge clk_sys);
		reset <= 1'b0;
		// Reset values, unmapped place, field widths
		for (int i = 0; i < 6; i++) begin
			rd(8'(i * 4), v);
			chk(v, 32'h0);
		end
		wr(8'h1C, 32'hFFFFFFFF);
		rd(8'h1C, v);
		chk(v, 32'h0);
		wr(`TSG_OFF_NUM, 32'hFFFFFFFF);
		rd(`TSG_OFF_NUM, v);
		chk(v, 32'h0000000F);
		@(posedge clk_sys);
		#1;
		chk(reg_rdata_q, 32'h0);
		wr(`TSG_OFF_DEN, 32'hFFFFFFFF);
		rd(`TSG_OFF_DEN, v);
		chk(v, 32'h000000FF);
		$display("test registers done");
		// Pulse mode: sync picks the level, range has no effect
		wr(`TSG_OFF_PULSE, 32'h0000110F);
		cfg(6'h0F);
		chk({31'h0, pulse_en_q}, 32'h1);
		chk({27'h0, pulse_code_q}, 32'h0F);
		sync_req <= 1'b1;
		idle(5);
		chk({27'h0, pulse_code_q}, 32'h11);
		cfg(6'h1B);
		chk({27'h0, pulse_code_q}, 32'h11);
		sync_req <= 1'b0;
		idle(5);
		chk({27'h0, pulse_code_q}, 32'h0F);
		$display("test pulse done");
		// Dc mode over every range code
		wr(`TSG_OFF_DC, 32'h00C00000);
		for (int r = 0; r < 8; r++) begin
			cfg({1'b0, 3'(r), 2'b01});
			chk({29'h0, dac_range_q}, (r == 7) ? 32'h6 : 32'(r));
			chk({8'h0, mod_sample_q}, 32'h00C00000);
			chk({26'h0, pulse_en_q, pulse_code_q}, 32'h0);
		end
		// Ones density follows the signed level
		for (int i = 0; i < 4; i++) begin
			wr(`TSG_OFF_DC, {8'h0, dcv[i]});
			idle(40);
			cnt = 0;
			repeat (1024) begin
				@(negedge clk_sys);
				cnt += dac_bit_q;
			end
			chk({31'h0, (cnt >= dce[i] - 40 && cnt <= dce[i] + 40)}, 32'h1);
		end
		$display("test dc done");
		// External stream passes straight through
		cfg(6'h02);
		chk({8'h0, mod_sample_q}, 32'h0);
		h = 4'h0;
		// Prime the three-stage history before comparing
		repeat (3) begin
			@(negedge clk_sys);
			h = {h[2:0], bit_pin};
		end
		repeat (80) begin
			@(negedge clk_sys);
			chk({31'h0, dac_bit_q}, {31'h0, h[2]});
			h = {h[2:0], bit_pin};
		end
		$display("test bitstream done");
		// Sine rate: phase advance over whole accumulator periods
		for (int i = 0; i < 5; i++) begin
			cfg({fo[i], 3'h0, 2'b00});
			wr(`TSG_OFF_NUM, {28'h0, fm[i]});
			wr(`TSG_OFF_DEN, {24'h0, fn[i]});
			rd(`TSG_OFF_STAT, v);
			chk({31'h0, (v[14:0] <= 15'h8)}, 32'h1);
			ph = v[14:0];
			idle(fk[i] - 2);
			rd(`TSG_OFF_STAT, v);
			chk({17'h0, v[14:0] - ph}, {17'h0, fe[i]});
		end
		// Sync high holds the phase at the zero crossing
		sync_req <= 1'b1;
		idle(6);
		rd(`TSG_OFF_STAT, v);
		chk({17'h0, v[14:0]}, 32'h0);
		idle(10);
		rd(`TSG_OFF_STAT, v);
		chk({17'h0, v[14:0]}, 32'h0);
		sync_req <= 1'b0;
		// Amplitude at the quarter period, then 6 dB down, then mute
		wr(`TSG_OFF_NUM, 32'h0);
		wr(`TSG_OFF_DEN, 32'h0);
		idle(4096);
		chk({28'h0, mod_sample_q[23:20]}, 32'h7);
		wr(`TSG_OFF_ATT, 32'h0000000C);
		idle(20);
		chk({28'h0, mod_sample_q[23:20]}, 32'h3);
		wr(`TSG_OFF_ATT, 32'h000000F5);
		idle(20);
		chk({8'h0, mod_sample_q}, 32'h0);
		idle(300);
		chk({8'h0, mod_sample_q}, 32'h0);
		$display("test sine done");
		summarize();
	end
endmodule // tb

`default_nettype wire
